// file: hw/sam_pkg.sv
/*
  Constants, register map and alarm tables of the servo alarm manager.
  Assumes a 250 MHz drive clock and APB access with one word per register.
*/
package sam_pkg;
  // Clock and time figures.
  localparam longint CLK_PERIOD_NS = 4;
  localparam longint NS_PER_S = 1000000000;
  localparam longint HOUR_S = 3600;
  localparam longint HOUR_CYCLES_DEF = HOUR_S * NS_PER_S / CLK_PERIOD_NS;
  localparam longint TRACE_SHORT_MS = 1000;
  localparam longint TRACE_LONG_MS = 10000;
  localparam longint NS_PER_MS = 1000000;
  localparam longint TRACE_SHORT_DEF = TRACE_SHORT_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam longint TRACE_LONG_DEF = TRACE_LONG_MS * NS_PER_MS / CLK_PERIOD_NS;

  // Register byte offsets.
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_HOURS = 8'h14;
  localparam logic [7:0] REG_HIST_SEL = 8'h18;
  localparam logic [7:0] REG_HIST_DATA = 8'h1C;
  localparam logic [7:0] REG_IO_MON = 8'h20;
  localparam logic [7:0] REG_TRIG = 8'h24;
  localparam logic [7:0] REG_DEV = 8'h28;
  localparam logic [7:0] REG_ALARMS = 8'h2C;
  localparam logic [7:0] REG_WARNS = 8'h30;

  // Field positions.
  localparam int CFG_DEVCLR_BIT = 0;
  localparam int CFG_FUNC_LSB = 1;
  localparam int CFG_LONG_BIT = 3;
  localparam int CMD_RESET_BIT = 0;
  localparam int CMD_CLRHIST_BIT = 1;
  localparam int CMD_ARM_BIT = 2;
  localparam int CMD_STOP_BIT = 3;
  localparam int IRQ_ALARM_BIT = 0;
  localparam int IRQ_WARN_BIT = 1;
  localparam int IRQ_CAP_BIT = 2;
  localparam logic [1:0] FUNC_INVERT = 2'h1;

  // Sizes.
  localparam int NUM_ALARMS = 30;
  localparam int NUM_WARNS = 10;
  localparam int HIST_DEPTH = 8;
  localparam int HIST_AW = 3;
  localparam int HOURS_W = 16;
  localparam int HIST_W = 24;
  localparam logic [3:0] HIST_FULL = 4'h8;

  // Trace time base limits in ms per division.
  localparam logic [10:0] TB_SHORT_MIN = 11'h005;
  localparam logic [10:0] TB_SHORT_MAX = 11'h064;
  localparam logic [10:0] TB_LONG_MIN = 11'h064;
  localparam logic [10:0] TB_LONG_MAX = 11'h3E8;
  localparam logic [10:0] TB_RESET = 11'h00A;

  // Alarm group codes and special indices.
  localparam logic [2:0] GRP_STOP = 3'h4;
  localparam logic [2:0] GRP_MEMORY = 3'h5;
  localparam logic [2:0] GRP_POWER = 3'h6;
  localparam logic [2:0] GRP_ENCODER = 3'h7;
  localparam logic [4:0] IDX_CTRL_VOLT_LOW = 5'h08;

  typedef enum logic [2:0] {
    CAP_IDLE = 3'b001,
    CAP_ARMED = 3'b010,
    CAP_ACQ = 3'b100
  } sam_cap_e;

  // Displayed two digit alarm number per alarm index, in BCD.
  localparam logic [7:0] ALARM_NUM [NUM_ALARMS] = '{
    8'h01, 8'h10, 8'h20, 8'h30, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45,
    8'h46, 8'h47, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h60, 8'h70,
    8'h71, 8'h72, 8'h73, 8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86};

  // Group code per alarm index.
  localparam logic [2:0] ALARM_GRP [NUM_ALARMS] = '{
    GRP_STOP, GRP_POWER, GRP_STOP, GRP_POWER, GRP_POWER, GRP_POWER,
    GRP_POWER, GRP_POWER, GRP_POWER, GRP_POWER, GRP_POWER, GRP_POWER,
    GRP_ENCODER, GRP_ENCODER, GRP_ENCODER, GRP_ENCODER, GRP_ENCODER,
    GRP_ENCODER, GRP_STOP, GRP_MEMORY, GRP_MEMORY, GRP_ENCODER,
    GRP_ENCODER, GRP_ENCODER, GRP_ENCODER, GRP_ENCODER, GRP_ENCODER,
    GRP_ENCODER, GRP_ENCODER, GRP_ENCODER};
endpackage

// file: hw/sam_hist_if.sv
/*
  Write and read port bundle between the alarm manager and its history store.
  Assumes both ends run on the same drive clock.
*/
interface sam_hist_if;
  logic wrEn;
  logic [sam_pkg::HIST_AW-1:0] wrAddr;
  logic [sam_pkg::HIST_W-1:0] wrData;
  logic [sam_pkg::HIST_AW-1:0] rdAddr;
  logic [sam_pkg::HIST_W-1:0] rdData;

  modport manager (output wrEn, output wrAddr, output wrData,
                   output rdAddr, input rdData);
  modport store (input wrEn, input wrAddr, input wrData,
                 input rdAddr, output rdData);
endinterface

// file: hw/sam_hist_mem.sv
/*
  Eight entry alarm history store with registered read data.
  Assumes the manager drives the port on the same clock; no reset of contents.
*/
module sam_hist_mem (
  // Clock.
  input wire logic mclk,
  // History port.
  sam_hist_if.store hist
);
  logic [sam_pkg::HIST_W-1:0] mem [sam_pkg::HIST_DEPTH];
  logic [sam_pkg::HIST_W-1:0] rdData_reg;

  // Write one entry and register the read word.
  always_ff @(posedge mclk)
  begin
    if (hist.wrEn)
    begin
      mem[hist.wrAddr] <= hist.wrData;
    end
    rdData_reg <= mem[hist.rdAddr];
  end

  assign hist.rdData = rdData_reg;
endmodule

// file: hw/sam_alarm_manager.sv
/*
  Alarm and warning manager of a servo drive, with APB registers, alarm
  history, I/O monitor, deviation counter and triggered capture control.
  Assumes detection logic drives alarm and warning conditions on mclk and
  that the servo-on, reset, clear and general inputs are asynchronous pins.
*/
// What this block does
// (RL1) Any alarm raises the alarm output and turns the servo loop off at once.
// (RL2) Warnings are flagged and reported but never turn the servo off.
// (RL3) A trip shows the two digit alarm number and the 3-bit group code.
// (RL4) History keeps the eight latest alarms with operating hours at occurrence; the code writes only the lowest index of alarms arriving in one cycle.
// (RL5) Code 100 for stop, overload, deviation; 101 for RAM and EEPROM faults.
// (RL6) Code 110 for overspeed, overcurrent, voltage, regeneration and power faults.
// (RL7) Code 111 for encoder, communication and logic array faults.
// (RL8) Only group 100 alarms clear by reset, and only after the cause has gone.
// (RL9) Output function setting 01 drives the alarm code bits inverted.
// (RL10) After an alarm reset, servo stays off until servo-on is dropped and raised.
// (RL11) Alarm reset leaves the position deviation counter unchanged.
// (RL12) Host clears deviation first, then pulses alarm reset.
// (RL13) With the clear-at-servo-on setting, deviation zeroes on every servo-on.
// (RL14) Control voltage low alarm is reported but never written to history.
// (RL15) Clear history erases all stored entries.
// (RL16) I/O monitor shows inputs ON when received, outputs ON when driving.
// (RL17) Armed capture waits for the trigger level before acquiring.
// (RL18) Time base 5 to 100 ms/div for 1000ms traces, 100 to 1000 for 10 s.
// (RL19) Group code follows the first latched alarm until it is cleared.
module sam_alarm_manager #(
  parameter logic [39:0] HOUR_CYCLES = 40'(sam_pkg::HOUR_CYCLES_DEF),
  parameter logic [31:0] TRACE_SHORT_CYCLES = 32'(sam_pkg::TRACE_SHORT_DEF),
  parameter logic [31:0] TRACE_LONG_CYCLES = 32'(sam_pkg::TRACE_LONG_DEF)
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive pins from the host.
  input wire logic servoOnPin,
  input wire logic alarmResetPin,
  input wire logic devClearPin,
  input wire logic [7:0] generalInPin,
  // Detection logic and position command pulses.
  input wire logic [sam_pkg::NUM_ALARMS-1:0] alarmCond,
  input wire logic [sam_pkg::NUM_WARNS-1:0] warnCond,
  input wire logic devUp,
  input wire logic devDown,
  input wire logic [15:0] capSample,
  // Outputs toward the host and the drive.
  output logic alarmOut,
  output logic warnOut,
  output logic servoEnable,
  output logic [2:0] alarm_group_code_bit,
  output logic [7:0] displayCode,
  output logic [31:0] devCount,
  output logic capAcquire,
  output logic irq
);
  localparam int NA = sam_pkg::NUM_ALARMS;

  // Synchronisers: stage A is read only by stage B.
  logic [10:0] syncA_reg;
  logic [10:0] syncB_reg;
  logic servoOnS, alarmResetS, devClearS;
  logic [7:0] generalInS;
  always_ff @(posedge mclk)
  begin
    syncA_reg <= {servoOnPin, alarmResetPin, devClearPin, generalInPin};
    syncB_reg <= syncA_reg;
  end
  assign {servoOnS, alarmResetS, devClearS, generalInS} = syncB_reg;

  // APB decode; the answer comes in the second access cycle.
  logic access, wrAcc, rdAcc, known, tbOk;
  logic [31:0] rdMux;
  assign access = psel & penable & ~pready;
  assign wrAcc = access & pwrite;
  assign rdAcc = access & ~pwrite;
  logic wCfg, wCmd, wIrqSt, wMask, wSel, wTrig;
  assign wCfg = wrAcc & (paddr == sam_pkg::REG_CFG);
  assign wCmd = wrAcc & (paddr == sam_pkg::REG_CMD);
  assign wIrqSt = wrAcc & (paddr == sam_pkg::REG_IRQ_STAT);
  assign wMask = wrAcc & (paddr == sam_pkg::REG_IRQ_MASK);
  assign wSel = wrAcc & (paddr == sam_pkg::REG_HIST_SEL);
  assign wTrig = wrAcc & (paddr == sam_pkg::REG_TRIG) & tbOk;

  // Configuration and control registers.
  logic [3:0] cfg_reg;
  logic [2:0] irqMask_reg, irqStat_reg, irqStat_next;
  logic [2:0] histSel_reg;
  logic [15:0] trigLevel_reg;
  logic [10:0] timeBase_reg;
  logic [10:0] tbNew;
  logic devClrAtOn, traceLong, cmdReset, cmdClrHist, cmdArm, cmdStop;
  logic [1:0] outFunc;
  assign devClrAtOn = cfg_reg[sam_pkg::CFG_DEVCLR_BIT];
  assign outFunc = cfg_reg[sam_pkg::CFG_FUNC_LSB +: 2];
  assign traceLong = cfg_reg[sam_pkg::CFG_LONG_BIT];
  assign cmdReset = wCmd & pwdata[sam_pkg::CMD_RESET_BIT];
  assign cmdClrHist = wCmd & pwdata[sam_pkg::CMD_CLRHIST_BIT];
  assign cmdArm = wCmd & pwdata[sam_pkg::CMD_ARM_BIT];
  assign cmdStop = wCmd & pwdata[sam_pkg::CMD_STOP_BIT];
  // A time base outside the range of the selected length is refused.
  assign tbNew = pwdata[26:16];
  assign tbOk = traceLong ?
    (tbNew >= sam_pkg::TB_LONG_MIN && tbNew <= sam_pkg::TB_LONG_MAX) :
    (tbNew >= sam_pkg::TB_SHORT_MIN && tbNew <= sam_pkg::TB_SHORT_MAX); // [RL18]

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cfg_reg <= 4'h0;
      irqMask_reg <= 3'h0;
      histSel_reg <= 3'h0;
      trigLevel_reg <= 16'h0000;
      timeBase_reg <= sam_pkg::TB_RESET;
    end
    else
    begin
      if (wCfg)
        cfg_reg <= pwdata[3:0];
      if (wMask)
        irqMask_reg <= pwdata[2:0];
      if (wSel)
        histSel_reg <= pwdata[2:0];
      if (wTrig)
      begin
        trigLevel_reg <= pwdata[15:0];
        timeBase_reg <= tbNew;
      end
    end
  end

  // Alarm latching; a reset request comes from the pin edge or software.
  logic resetPrev_reg;
  logic resetReq;
  logic [NA-1:0] latch_reg, latch_next, clearable, newAlarm;
  assign resetReq = (alarmResetS & ~resetPrev_reg) | cmdReset;
  always_comb
  begin
    for (int i = 0; i < NA; i++)
    begin
      clearable[i] = (sam_pkg::ALARM_GRP[i] == sam_pkg::GRP_STOP) &
                     ~alarmCond[i]; // [RL8]
    end
  end
  assign newAlarm = alarmCond & ~latch_reg;
  // A condition that is still present wins over the clear.
  assign latch_next = alarmCond |
    (latch_reg & ~({NA{resetReq}} & clearable)); // [RL8]

  // First latched alarm: kept until cleared, then the lowest pending one.
  logic [4:0] firstIdx_reg, firstIdx_next, lowPend, lowNew;
  logic firstValid_reg, firstValid_next;
  always_comb
  begin
    lowPend = 5'h00;
    lowNew = 5'h00;
    for (int i = NA - 1; i >= 0; i--)
    begin
      if (latch_next[i])
        lowPend = 5'(i);
      if (newAlarm[i])
        lowNew = 5'(i);
    end
  end
  always_comb
  begin
    firstIdx_next = firstIdx_reg;
    firstValid_next = |latch_next;
    if (!firstValid_reg || !latch_next[firstIdx_reg])
      firstIdx_next = lowPend; // [RL19]
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      latch_reg <= '0;
      firstIdx_reg <= 5'h00;
      firstValid_reg <= 1'b0;
      resetPrev_reg <= 1'b0;
    end
    else
    begin
      latch_reg <= latch_next;
      firstIdx_reg <= firstIdx_next;
      firstValid_reg <= firstValid_next;
      resetPrev_reg <= alarmResetS;
    end
  end

  // Servo gate: an alarm turns it off in the same cycle the alarm is seen.
  // After any alarm, servo-on must be dropped once before it may act again.
  logic needRelease_reg;
  logic anyAlarmNext, servoNext;
  assign anyAlarmNext = |latch_next;
  assign servoNext = servoOnS & ~anyAlarmNext & ~needRelease_reg &
                     ~(|latch_reg); // [RL1] [RL2] [RL10]
  always_ff @(posedge mclk)
  begin
    if (srst)
      needRelease_reg <= 1'b0;
    else if (|latch_reg)
      needRelease_reg <= 1'b1; // [RL10]
    else if (!servoOnS)
      needRelease_reg <= 1'b0;
  end

  // Group code and display; function 01 inverts the code bits.
  logic [2:0] grpNext, codePinNext, grpReg;
  logic [7:0] dispNext;
  assign grpNext = firstValid_next ?
    sam_pkg::ALARM_GRP[firstIdx_next] : 3'h0; // [RL3] [RL5] [RL6] [RL7]
  assign dispNext = firstValid_next ?
    sam_pkg::ALARM_NUM[firstIdx_next] : 8'h00; // [RL3]
  assign codePinNext = (outFunc == sam_pkg::FUNC_INVERT) ?
    ~grpNext : grpNext; // [RL9]

  // Operating hours counter.
  logic [39:0] hourTick_reg;
  logic [sam_pkg::HOURS_W-1:0] hours_reg;
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      hourTick_reg <= 40'h0;
      hours_reg <= '0;
    end
    else if (hourTick_reg == HOUR_CYCLES - 40'h1)
    begin
      hourTick_reg <= 40'h0;
      hours_reg <= hours_reg + 16'h1;
    end
    else
      hourTick_reg <= hourTick_reg + 40'h1;
  end

  // History writer; one new alarm per cycle is recorded, only the lowest index
  // of those arriving together, since they share the same hour stamp anyway.
  sam_hist_if histBus ();
  logic [2:0] wrPtr_reg;
  logic [3:0] histCount_reg;
  logic histWrite;
  assign histWrite = (|newAlarm) & (lowNew != sam_pkg::IDX_CTRL_VOLT_LOW)
                     & ~cmdClrHist; // [RL4] [RL14]
  assign histBus.wrEn = histWrite;
  assign histBus.wrAddr = wrPtr_reg;
  assign histBus.wrData = {hours_reg, sam_pkg::ALARM_NUM[lowNew]}; // [RL4]
  assign histBus.rdAddr = 3'(wrPtr_reg - 3'h1 - histSel_reg);
  always_ff @(posedge mclk)
  begin
    if (srst || cmdClrHist)
    begin
      wrPtr_reg <= 3'h0; // [RL15]
      histCount_reg <= 4'h0; // [RL15]
    end
    else if (histWrite)
    begin
      wrPtr_reg <= wrPtr_reg + 3'h1;
      if (histCount_reg != sam_pkg::HIST_FULL)
        histCount_reg <= histCount_reg + 4'h1;
    end
  end

  sam_hist_mem histStore (
    .mclk(mclk),
    .hist(histBus.store)
  );

  // Deviation counter; alarm reset does not touch it, only the clear pin
  // edge or a servo-on edge with the setting enabled.
  logic servoOnPrev_reg, devClrPrev_reg, devZero;
  logic [31:0] dev_reg;
  assign devZero = (devClearS & ~devClrPrev_reg) |
    (devClrAtOn & servoOnS & ~servoOnPrev_reg); // [RL11] [RL12] [RL13]
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      dev_reg <= 32'h0;
      servoOnPrev_reg <= 1'b0;
      devClrPrev_reg <= 1'b0;
    end
    else
    begin
      servoOnPrev_reg <= servoOnS;
      devClrPrev_reg <= devClearS;
      if (devZero)
        dev_reg <= 32'h0; // [RL13]
      else if (devUp & ~devDown)
        dev_reg <= dev_reg + 32'h1;
      else if (devDown & ~devUp)
        dev_reg <= dev_reg - 32'h1;
    end
  end

  // Capture sequencer: armed waits for the level, then acquires the trace.
  sam_pkg::sam_cap_e cap_reg, cap_next;
  logic [31:0] capCnt_reg;
  logic [31:0] traceLen;
  logic capDone;
  assign traceLen = traceLong ? TRACE_LONG_CYCLES : TRACE_SHORT_CYCLES;
  assign capDone = (cap_reg == sam_pkg::CAP_ACQ) &
                   (capCnt_reg == traceLen - 32'h1);
  always_comb
  begin
    cap_next = cap_reg;
    unique case (cap_reg)
      sam_pkg::CAP_IDLE:
        if (cmdArm)
          cap_next = sam_pkg::CAP_ARMED;
      sam_pkg::CAP_ARMED:
        if (cmdStop)
          cap_next = sam_pkg::CAP_IDLE;
        else if (capSample >= trigLevel_reg)
          cap_next = sam_pkg::CAP_ACQ; // [RL17]
      sam_pkg::CAP_ACQ:
        if (cmdStop || capDone)
          cap_next = sam_pkg::CAP_IDLE;
      default:
        cap_next = sam_pkg::CAP_IDLE;
    endcase
  end
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cap_reg <= sam_pkg::CAP_IDLE;
      capCnt_reg <= 32'h0;
    end
    else
    begin
      cap_reg <= cap_next;
      capCnt_reg <= (cap_next == sam_pkg::CAP_ACQ) ?
                    capCnt_reg + 32'h1 : 32'h0;
    end
  end

  // Sticky interrupt status, write one to clear; a new event wins.
  logic [2:0] irqEvent;
  logic [sam_pkg::NUM_WARNS-1:0] warnPrev_reg;
  assign irqEvent = {capDone, |(warnCond & ~warnPrev_reg), |newAlarm};
  assign irqStat_next = (irqStat_reg & ~({3{wIrqSt}} & pwdata[2:0]))
                        | irqEvent;

  // Read multiplexer.
  // The map is dense, so any aligned word up to the last register is known.
  assign known = (paddr <= sam_pkg::REG_WARNS) & (paddr[1:0] == 2'h0);
  always_comb
  begin
    rdMux = 32'h0;
    unique case (paddr)
      sam_pkg::REG_CFG: rdMux = {28'h0, cfg_reg};
      sam_pkg::REG_STAT: rdMux = {15'h0, cap_reg, displayCode, grpReg,
        servoEnable, warnOut, alarmOut};
      sam_pkg::REG_IRQ_STAT: rdMux = {29'h0, irqStat_reg};
      sam_pkg::REG_IRQ_MASK: rdMux = {29'h0, irqMask_reg};
      sam_pkg::REG_HOURS: rdMux = {16'h0, hours_reg};
      sam_pkg::REG_HIST_SEL: rdMux = {29'h0, histSel_reg};
      sam_pkg::REG_HIST_DATA: rdMux = (histSel_reg < 3'(histCount_reg) ||
        histCount_reg == sam_pkg::HIST_FULL) ?
        {4'h0, histCount_reg, histBus.rdData} : {4'h0, histCount_reg, 24'h0};
      sam_pkg::REG_IO_MON: rdMux = {18'h0, capAcquire, servoEnable,
        alarm_group_code_bit, alarmOut, generalInS}; // [RL16]
      sam_pkg::REG_TRIG: rdMux = {5'h0, timeBase_reg, trigLevel_reg};
      sam_pkg::REG_DEV: rdMux = dev_reg;
      sam_pkg::REG_ALARMS: rdMux = {2'h0, latch_reg};
      sam_pkg::REG_WARNS: rdMux = {22'h0, warnPrev_reg};
      default: rdMux = 32'h0;
    endcase
  end

  // Registered outputs, APB answer and status.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
      irqStat_reg <= 3'h0;
      warnPrev_reg <= '0;
      alarmOut <= 1'b0;
      warnOut <= 1'b0;
      servoEnable <= 1'b0;
      grpReg <= 3'h0;
      alarm_group_code_bit <= 3'h0;
      displayCode <= 8'h00;
      devCount <= 32'h0;
      capAcquire <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      pready <= access;
      prdata <= rdAcc ? rdMux : 32'h0;
      pslverr <= access & (~known |
        (pwrite & (paddr == sam_pkg::REG_TRIG) & ~tbOk)); // [RL18]
      irqStat_reg <= irqStat_next;
      warnPrev_reg <= warnCond;
      alarmOut <= anyAlarmNext; // [RL1]
      warnOut <= |warnCond; // [RL2]
      servoEnable <= servoNext; // [RL1]
      grpReg <= grpNext;
      alarm_group_code_bit <= codePinNext; // [RL3] [RL9]
      displayCode <= dispNext; // [RL3]
      devCount <= dev_reg;
      capAcquire <= cap_next == sam_pkg::CAP_ACQ; // [RL17]
      irq <= |(irqStat_next & irqMask_reg);
    end
  end
endmodule

// file: test/sam_alarm_monitor.sv
/*
  Port checks on the alarm manager.
  Assumes binding to sam_alarm_manager; sees its ports only.
*/
module sam_alarm_monitor (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // APB side.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Pins and conditions.
  input wire logic servoOnPin,
  input wire logic [sam_pkg::NUM_ALARMS-1:0] alarmCond,
  input wire logic [sam_pkg::NUM_WARNS-1:0] warnCond,
  // Outputs.
  input wire logic alarmOut,
  input wire logic warnOut,
  input wire logic servoEnable,
  input wire logic [2:0] alarm_group_code_bit,
  input wire logic [7:0] displayCode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic invert_reg;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  // Shadow of the output function setting, taken when a CFG write lands.
  always_ff @(posedge mclk)
  begin
    if (srst)
      invert_reg <= 1'b0;
    else if (psel && penable && !pready && pwrite &&
      paddr == sam_pkg::REG_CFG)
      invert_reg <= pwdata[2:1] == sam_pkg::FUNC_INVERT;
  end

  alarm_stops_a: assert property (
    |alarmCond |=> alarmOut && !servoEnable)
    else $error("alarm did not stop the servo");
  servo_held_off_a: assert property (
    alarmOut |-> !servoEnable)
    else $error("servo on while alarm latched");
  warn_flag_a: assert property (
    |warnCond |=> warnOut)
    else $error("warning not flagged");
  warn_keeps_servo_a: assert property (
    (servoOnPin && servoEnable)[*3] ##0 alarmCond == '0 |=> servoEnable)
    else $error("servo dropped without alarm");
  code_shown_a: assert property (
    $rose(alarmOut) |->
      displayCode != 8'h00 && alarm_group_code_bit[2] == !invert_reg)
    else $error("no alarm number or code");
  stop_group_a: assert property (
    !alarmOut && alarmCond[0] |=>
      alarm_group_code_bit == (invert_reg ? 3'h3 : 3'h4))
    else $error("wrong stop group code");
  encoder_group_a: assert property (
    !alarmOut && alarmCond == 30'h2000_0000 |=>
      alarm_group_code_bit == (invert_reg ? 3'h0 : 3'h7))
    else $error("wrong encoder group code");
  fault_latched_a: assert property (
    alarmOut && alarm_group_code_bit != 3'h4 &&
      alarm_group_code_bit != 3'h3 |=> alarmOut)
    else $error("non-clearable alarm released");
  rearm_needed_a: assert property (
    $fell(alarmOut) ##0 servoOnPin[*4] |-> !servoEnable)
    else $error("servo back on without re-arm");
endmodule

bind sam_alarm_manager sam_alarm_monitor u_monitor (.*);

// file: test/sam_host_model.sv
/*
  Host controller model for the drive pins.
  Assumes its tasks are called just after a rising edge of mclk.
*/
module sam_host_model (
  // Clock.
  input wire logic mclk,
  // Drive pins.
  output logic servoOnPin,
  output logic alarmResetPin,
  output logic devClearPin,
  output logic [7:0] generalInPin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins start released.
  initial
  begin
    servoOnPin = 1'b0;
    alarmResetPin = 1'b0;
    devClearPin = 1'b0;
    generalInPin = 8'h00;
  end

  // Six edges let the synchronisers see each level.
  task automatic hold();
    repeat (6) @(posedge mclk);
  endtask

  // Servo must drop before it is raised again.
  task automatic servo(input logic on);
    servoOnPin <= on;
    hold();
  endtask

  // Deviation clear always comes before the alarm reset pulse.
  task automatic recover();
    devClearPin <= 1'b1;
    hold();
    devClearPin <= 1'b0;
    hold();
    alarmResetPin <= 1'b1;
    hold();
    alarmResetPin <= 1'b0;
    hold();
  endtask

  // General input levels.
  task automatic inputs(input logic [7:0] v);
    generalInPin <= v;
    hold();
  endtask
endmodule

// file: test/sam_alarm_manager_test.sv
/*
  Directed bench for the alarm manager over APB and host pins.
  Assumes the package compiles first.
*/
module sam_alarm_manager_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, devCount, rd;
  logic pready, pslverr, err, devUp = 1'b0, devDown = 1'b0;
  logic servoOnPin, alarmResetPin, devClearPin;
  logic [7:0] generalInPin, displayCode;
  logic [29:0] alarmCond = 30'h0;
  logic [9:0] warnCond = 10'h000;
  logic [15:0] capSample = 16'h0000;
  logic alarmOut, warnOut, servoEnable, capAcquire, irq;
  logic [2:0] alarm_group_code_bit;
  int nMismatch = 0, checkCount = 0, cycles = 0;
  int idx[4] = '{0, 8, 19, 29};
  logic [2:0] grp[4] = '{3'h4, 3'h6, 3'h5, 3'h7};
  logic [7:0] num[4] = '{8'h01, 8'h44, 8'h70, 8'h86};
  logic [5:0] tbLong = 6'b111000, tbErr = 6'b101001;
  logic [10:0] tbVal[6] = '{11'h004, 11'h005, 11'h064, 11'h063, 11'h3E8,
    11'h3E9};

  // Short hour and trace counts keep the run brief.
  sam_alarm_manager #(.HOUR_CYCLES(40'h64), .TRACE_SHORT_CYCLES(32'h14),
    .TRACE_LONG_CYCLES(32'h32)) u_dut (.mclk, .srst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .servoOnPin,
    .alarmResetPin, .devClearPin, .generalInPin, .alarmCond, .warnCond,
    .devUp, .devDown, .capSample, .alarmOut, .warnOut, .servoEnable,
    .alarm_group_code_bit, .displayCode, .devCount, .capAcquire, .irq);
  sam_host_model u_host (.mclk, .servoOnPin, .alarmResetPin, .devClearPin,
    .generalInPin);

  // Clock at 4 ns.
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // A hang is cut off well beyond the directed run.
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      nMismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask

  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    cyc(10);
    srst <= 1'b0;
    cyc(1);
  endtask

  // Main sequence.
  initial
  begin
    do_reset();
    apb(1'b0, sam_pkg::REG_STAT, 32'h0);
    check("stat", rd, 32'h0000_4000);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    apb(1'b0, sam_pkg::REG_TRIG, 32'h0);
    check("trig", rd, 32'h000A_0000);
    $display("test reset done");
    apb(1'b1, sam_pkg::REG_CFG, 32'h1);
    apb(1'b1, sam_pkg::REG_IRQ_MASK, 32'h1);
    u_host.servo(1'b1);
    warnCond <= 10'h001;
    devUp <= 1'b1;
    cyc(3);
    check("warn", {warnOut, servoEnable}, 32'h3);
    warnCond <= 10'h000;
    devUp <= 1'b0;
    devDown <= 1'b1;
    alarmCond <= 30'h1;
    cyc(1);
    devDown <= 1'b0;
    cyc(2);
    check("alarm", {alarmOut, servoEnable, irq, alarm_group_code_bit,
      displayCode}, {3'b101, 3'h4, 8'h01});
    apb(1'b1, sam_pkg::REG_CMD, 32'h1);
    check("held", alarmOut, 32'h1);
    alarmCond <= 30'h0;
    apb(1'b1, sam_pkg::REG_CMD, 32'h1);
    apb(1'b1, sam_pkg::REG_IRQ_STAT, 32'h1);
    check("cleared", {alarmOut, servoEnable, irq}, 32'h0);
    check("dev kept", devCount, 32'h2);
    u_host.servo(1'b0);
    u_host.servo(1'b1);
    check("rearm", {servoEnable, devCount[30:0]}, {1'b1, 31'h0});
    $display("test clearable done");
    // One alarm per group after a reset, with history.
    for (int i = 0; i < 4; i++)
    begin
      alarmCond <= 30'h0;
      do_reset();
      apb(1'b1, sam_pkg::REG_CMD, 32'h2);
      alarmCond <= 30'h1 << idx[i];
      cyc(3);
      check("group", {alarm_group_code_bit, displayCode},
        {grp[i], num[i]});
      apb(1'b1, sam_pkg::REG_HIST_SEL, 32'h0);
      apb(1'b0, sam_pkg::REG_HIST_DATA, 32'h0);
      check("history", rd & 32'h0F00_00FF,
        (i == 1) ? 32'h0 : {8'h01, 16'h0, num[i]});
    end
    $display("test groups done");
    apb(1'b1, sam_pkg::REG_CFG, 32'h2);
    alarmCond <= 30'h2000_0100;
    cyc(3);
    check("inverted", {alarm_group_code_bit, displayCode},
      32'h086);
    u_host.recover();
    check("latched", alarmOut, 32'h1);
    u_host.inputs(8'hA5);
    apb(1'b0, sam_pkg::REG_IO_MON, 32'h0);
    check("io", rd[12:0], 32'h01A5);
    apb(1'b0, sam_pkg::REG_HIST_DATA, 32'h0);
    check("no low volt", rd & 32'h0F00_00FF, 32'h0100_0086);
    apb(1'b1, sam_pkg::REG_CMD, 32'h2);
    apb(1'b0, sam_pkg::REG_HIST_DATA, 32'h0);
    check("hist cleared", rd, 32'h0);
    $display("test latched done");
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, sam_pkg::REG_CFG, {28'h0, tbLong[i], 3'h0});
      apb(1'b1, sam_pkg::REG_TRIG, {5'h0, tbVal[i], 16'h0064});
      check("timebase", err, tbErr[i]);
    end
    capSample <= 16'h0063;
    apb(1'b1, sam_pkg::REG_CMD, 32'h4);
    cyc(5);
    check("waiting", capAcquire, 32'h0);
    capSample <= 16'h0064;
    cyc(3);
    check("acquire", capAcquire, 32'h1);
    cyc(60);
    check("trace end", capAcquire, 32'h0);
    $display("test capture done");
    report_and_stop();
  end
endmodule
